// ---- hdl/nvmc_ctrl.sv ----
`timescale 1ns/100ps
module nvmc_ctrl
	import nvmc_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = WRITE_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// device reset other than power-on
	input  wire logic        abort_reset,
	// memory array side
	output logic             mem_prog_sel,
	output logic             mem_cfg_sel,
	output logic             mem_row_erase,
	output logic             mem_write_start,
	output logic             mem_read_strobe,
	output logic             mem_write_busy,
	// interrupt
	output logic             irq
);

	typedef struct packed {
		logic [7:0]      ctrl;
		logic [EV_W-1:0] stat;
		logic [EV_W-1:0] mask;
		logic            irq;
		logic            wr_start;
		logic            rd_strobe;
		logic [31:0]     hrdata;
		logic            hreadyout;
		logic            pend_we;
		nvmc_idx_t       pend_idx;
	} nvmc_state_t;

	nvmc_state_t q;
	nvmc_state_t d;
	logic        tmr_busy;
	logic        tmr_done;

	// control register write in its data phase
	logic ctrl_wr;
	assign ctrl_wr = q.pend_we && (q.pend_idx == NVMC_IDX_CTRL);

	always_comb begin
		logic [7:0]      wval;
		logic [EV_W-1:0] ev;
		logic            take;
		logic            abort_hit;
		logic            stat_rd;
		nvmc_idx_t       idx;
		wval = hwdata[7:0];
		ev = '0;
		idx = nvmc_reg_index(haddr[7:0]);
		take = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
		stat_rd = take && !hwrite && (idx == NVMC_IDX_STAT);
		// a completion in the same cycle as the reset counts as finished
		abort_hit = abort_reset && q.ctrl[WRITE_START_BIT] && !tmr_done;

		d = q;
		d.wr_start = 1'b0;
		d.rd_strobe = 1'b0;
		d.hreadyout = 1'b1;

		if (tmr_done) begin
			d.ctrl[WRITE_START_BIT] = 1'b0;
			d.ctrl[ROW_ERASE_BIT] = 1'b0;
			ev[EV_WRITE_DONE] = 1'b1;
		end
		if (q.ctrl[READ_START_BIT]) begin
			d.ctrl[READ_START_BIT] = 1'b0;
			ev[EV_READ_DONE] = 1'b1;
		end

		if (ctrl_wr) begin
			d.ctrl[WRITE_ERROR_BIT] = wval[WRITE_ERROR_BIT];
			d.ctrl[WRITE_PERMIT_BIT] = wval[WRITE_PERMIT_BIT];
			// selects are frozen while a cycle runs so the target cannot shift under it
			if (!q.ctrl[WRITE_START_BIT]) begin
				d.ctrl[PROG_SEL_BIT] = wval[PROG_SEL_BIT];
				d.ctrl[CONFIG_SEL_BIT] = wval[CONFIG_SEL_BIT];
				d.ctrl[ROW_ERASE_BIT] = wval[ROW_ERASE_BIT];
			end
			// zero written to either start bit is simply not acted on
			if (wval[WRITE_START_BIT] && !q.ctrl[WRITE_START_BIT]) begin
				if (wval[WRITE_PERMIT_BIT]) begin
					d.ctrl[WRITE_START_BIT] = 1'b1;
					d.wr_start = 1'b1;
				end else begin
					d.ctrl[WRITE_ERROR_BIT] = 1'b1;
					ev[EV_WRITE_ERROR] = 1'b1;
				end
			end else if (wval[READ_START_BIT] && !q.ctrl[WRITE_START_BIT]
					&& !d.ctrl[PROG_SEL_BIT] && !d.ctrl[CONFIG_SEL_BIT]) begin
				d.ctrl[READ_START_BIT] = 1'b1;
				d.rd_strobe = 1'b1;
			end
		end

		if (q.pend_we && (q.pend_idx == NVMC_IDX_MASK))
			d.mask = hwdata[EV_W-1:0];

		// reset overrides the start, permit and erase bits; selects survive so the failed target stays visible
		if (abort_reset) begin
			d.ctrl[WRITE_START_BIT] = 1'b0;
			d.ctrl[WRITE_PERMIT_BIT] = 1'b0;
			d.ctrl[ROW_ERASE_BIT] = 1'b0;
			d.ctrl[READ_START_BIT] = 1'b0;
			d.wr_start = 1'b0;
			d.rd_strobe = 1'b0;
			if (abort_hit) begin
				d.ctrl[WRITE_ERROR_BIT] = 1'b1;
				ev[EV_WRITE_ERROR] = 1'b1;
			end
		end

		// read clears only what was there before; a same-cycle event survives
		d.stat = (stat_rd ? STAT_RESET : q.stat) | ev;
		d.irq = |(d.stat & d.mask);

		d.pend_we = take && hwrite;
		d.pend_idx = take ? idx : NVMC_IDX_NONE;
		if (take && !hwrite) begin
			unique case (idx)
				NVMC_IDX_CTRL: d.hrdata = {24'h000000, d.ctrl & CTRL_IMPL_MASK};
				NVMC_IDX_STAT: d.hrdata = {29'h00000000, q.stat};
				NVMC_IDX_MASK: d.hrdata = {29'h00000000, d.mask};
				NVMC_IDX_NONE: d.hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
			q.stat <= STAT_RESET;
			q.mask <= MASK_RESET;
			q.pend_idx <= NVMC_IDX_NONE;
		end else begin
			q <= d;
		end
	end

	nvmc_prog_timer #(
		.CYCLES (PROG_CYCLES)
	) u_timer (
		.clk   (clk),
		.rst_b (rst_b),
		.start (q.wr_start),
		.abort (abort_reset),
		.busy  (tmr_busy),
		.done  (tmr_done)
	);

	assign hreadyout       = q.hreadyout;
	assign hrdata          = q.hrdata;
	assign hresp           = 1'b0;
	assign mem_prog_sel    = q.ctrl[PROG_SEL_BIT];
	assign mem_cfg_sel     = q.ctrl[CONFIG_SEL_BIT];
	assign mem_row_erase   = q.ctrl[ROW_ERASE_BIT];
	assign mem_write_start = q.wr_start;
	assign mem_read_strobe = q.rd_strobe;
	assign mem_write_busy  = tmr_busy;
	assign irq             = q.irq;

	a_wr_start_seen: assert property (@(posedge clk) disable iff (!rst_b)
		ctrl_wr && hwdata[WRITE_START_BIT] && hwdata[WRITE_PERMIT_BIT]
			&& !q.ctrl[WRITE_START_BIT] && !abort_reset
		// a device reset in the launch cycle keeps the timer idle, which is legal
		|=> q.ctrl[WRITE_START_BIT] && q.wr_start ##1 !q.wr_start && (tmr_busy || $past(abort_reset)))
		else $error("write start did not launch a timed cycle");

	a_wr_hw_clear: assert property (@(posedge clk) disable iff (!rst_b)
		tmr_done |=> !q.ctrl[WRITE_START_BIT] && !q.ctrl[ROW_ERASE_BIT])
		else $error("write start bit not cleared at completion");

	a_wr_set_only: assert property (@(posedge clk) disable iff (!rst_b)
		q.ctrl[WRITE_START_BIT] && !tmr_done && !abort_reset |=> q.ctrl[WRITE_START_BIT])
		else $error("write start bit cleared without completion");

	a_wr_zero_idle: assert property (@(posedge clk) disable iff (!rst_b)
		!q.ctrl[WRITE_START_BIT] |-> !tmr_busy)
		else $error("cycle running while write start bit reads zero");

	a_rd_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
		q.ctrl[READ_START_BIT] |-> q.rd_strobe ##1 ((!q.ctrl[READ_START_BIT] && !q.rd_strobe)
			|| $past(ctrl_wr && hwdata[READ_START_BIT])))
		else $error("read start did not finish in one cycle");

	a_rd_set_only: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(q.ctrl[READ_START_BIT]) |-> $past(ctrl_wr && hwdata[READ_START_BIT]))
		else $error("read start bit set without a software write");

	a_rd_blocked: assert property (@(posedge clk) disable iff (!rst_b)
		q.ctrl[READ_START_BIT] |-> !q.ctrl[PROG_SEL_BIT] && !q.ctrl[CONFIG_SEL_BIT])
		else $error("read started with program or config select set");

	a_err_improper: assert property (@(posedge clk) disable iff (!rst_b)
		ctrl_wr && hwdata[WRITE_START_BIT] && !hwdata[WRITE_PERMIT_BIT] && !q.ctrl[WRITE_START_BIT]
		|=> q.ctrl[WRITE_ERROR_BIT] && !q.ctrl[WRITE_START_BIT] && !tmr_busy)
		else $error("unpermitted write start not flagged");

	a_err_abort: assert property (@(posedge clk) disable iff (!rst_b)
		abort_reset && q.ctrl[WRITE_START_BIT] && !tmr_done
		|=> q.ctrl[WRITE_ERROR_BIT] && !q.ctrl[WRITE_START_BIT] ##1 !tmr_done)
		else $error("reset during programming not flagged");

	a_sel_hold: assert property (@(posedge clk) disable iff (!rst_b)
		abort_reset && q.ctrl[WRITE_START_BIT]
		|=> $stable(q.ctrl[PROG_SEL_BIT]) && $stable(q.ctrl[CONFIG_SEL_BIT]))
		else $error("select bits changed on write error");

	a_err_keep: assert property (@(posedge clk) disable iff (!rst_b)
		q.ctrl[WRITE_ERROR_BIT] && !ctrl_wr |=> q.ctrl[WRITE_ERROR_BIT])
		else $error("error flag lost without a software write");

	a_done_clean: assert property (@(posedge clk) disable iff (!rst_b)
		tmr_done && !q.ctrl[WRITE_ERROR_BIT] && !ctrl_wr |=> !q.ctrl[WRITE_ERROR_BIT])
		else $error("normal completion raised the error flag");

	a_err_event: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(q.ctrl[WRITE_ERROR_BIT]) && !$past(ctrl_wr && hwdata[WRITE_ERROR_BIT])
		|-> q.stat[EV_WRITE_ERROR])
		else $error("hardware error flag without a status event");

	a_start_permit: assert property (@(posedge clk) disable iff (!rst_b)
		q.wr_start
		|-> q.ctrl[WRITE_PERMIT_BIT])
		else $error("write launched without write permit");

	a_no_permit_block: assert property (@(posedge clk) disable iff (!rst_b)
		ctrl_wr && !hwdata[WRITE_PERMIT_BIT]
		|=> !q.wr_start)
		else $error("write launched by an unpermitted control write");

	a_start_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		q.wr_start
		|=> !q.wr_start)
		else $error("write launch pulse longer than one cycle");

	a_start_bit_set: assert property (@(posedge clk) disable iff (!rst_b)
		q.wr_start
		|-> q.ctrl[WRITE_START_BIT])
		else $error("write launch without the write start bit");

	a_wr_sw_set: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(q.ctrl[WRITE_START_BIT])
		|-> $past(ctrl_wr && hwdata[WRITE_START_BIT] && hwdata[WRITE_PERMIT_BIT]))
		else $error("write start bit set without a permitted write");

	a_done_while_set: assert property (@(posedge clk) disable iff (!rst_b)
		tmr_done
		|-> q.ctrl[WRITE_START_BIT])
		else $error("completion seen with write start bit clear");

	a_done_event: assert property (@(posedge clk) disable iff (!rst_b)
		tmr_done
		|=> q.stat[EV_WRITE_DONE])
		else $error("completion not recorded in status");

	a_rd_event: assert property (@(posedge clk) disable iff (!rst_b)
		q.ctrl[READ_START_BIT]
		|=> q.stat[EV_READ_DONE])
		else $error("read completion not recorded in status");

	a_rd_not_busy: assert property (@(posedge clk) disable iff (!rst_b)
		q.ctrl[READ_START_BIT]
		|-> !q.ctrl[WRITE_START_BIT])
		else $error("read started while a write cycle runs");

	a_abort_clears: assert property (@(posedge clk) disable iff (!rst_b)
		abort_reset
		|=> !q.ctrl[WRITE_START_BIT] && !q.ctrl[READ_START_BIT] && !q.ctrl[WRITE_PERMIT_BIT])
		else $error("device reset left a start or permit bit set");

	a_abort_stops: assert property (@(posedge clk) disable iff (!rst_b)
		abort_reset
		|=> !tmr_busy)
		else $error("timer kept running through a device reset");

	a_sel_frozen: assert property (@(posedge clk) disable iff (!rst_b)
		q.ctrl[WRITE_START_BIT]
		|=> $stable(q.ctrl[PROG_SEL_BIT]) && $stable(q.ctrl[CONFIG_SEL_BIT]))
		else $error("select bits moved during a write cycle");

	a_err_sw_clear: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(q.ctrl[WRITE_ERROR_BIT])
		|-> $past(ctrl_wr && !hwdata[WRITE_ERROR_BIT]))
		else $error("error flag cleared without a software write");

endmodule // nvmc_ctrl

// ---- shared/nvmc_pkg.sv ----
package nvmc_pkg;

	// clock and programming time
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned WRITE_TIME_US = 2000;
	localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

	// register byte offsets
	localparam logic [7:0] CTRL_OFF     = 8'h00;
	localparam logic [7:0] IRQ_STAT_OFF = 8'h04;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h08;

	// control register fields
	localparam int unsigned READ_START_BIT   = 0;
	localparam int unsigned WRITE_START_BIT  = 1;
	localparam int unsigned WRITE_PERMIT_BIT = 2;
	localparam int unsigned WRITE_ERROR_BIT  = 3;
	localparam int unsigned ROW_ERASE_BIT    = 4;
	localparam int unsigned CONFIG_SEL_BIT   = 6;
	localparam int unsigned PROG_SEL_BIT     = 7;
	localparam logic [7:0]  CTRL_RESET       = 8'h00;
	localparam logic [7:0]  CTRL_IMPL_MASK   = 8'hdf;

	// interrupt event bits
	localparam int unsigned EV_WRITE_DONE  = 0;
	localparam int unsigned EV_WRITE_ERROR = 1;
	localparam int unsigned EV_READ_DONE   = 2;
	localparam int unsigned EV_W           = 3;
	localparam logic [2:0]  STAT_RESET     = 3'h0;
	localparam logic [2:0]  MASK_RESET     = 3'h0;

	// bus constants
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		NVMC_IDX_CTRL = 2'b00,
		NVMC_IDX_STAT = 2'b01,
		NVMC_IDX_MASK = 2'b10,
		NVMC_IDX_NONE = 2'b11
	} nvmc_idx_t;

	typedef enum logic {
		NVMC_T_IDLE = 1'b0,
		NVMC_T_RUN  = 1'b1
	} nvmc_tstate_t;

	function automatic nvmc_idx_t nvmc_reg_index(input logic [7:0] off);
		nvmc_idx_t idx;
		idx = NVMC_IDX_NONE;
		if (off == CTRL_OFF)
			idx = NVMC_IDX_CTRL;
		else if (off == IRQ_STAT_OFF)
			idx = NVMC_IDX_STAT;
		else if (off == IRQ_MASK_OFF)
			idx = NVMC_IDX_MASK;
		return idx;
	endfunction

endpackage

// ---- hdl/nvmc_prog_timer.sv ----
`timescale 1ns/100ps
module nvmc_prog_timer
	import nvmc_pkg::*;
#(
	parameter int unsigned CYCLES = WRITE_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// control
	input  wire logic start,
	input  wire logic abort,
	// status
	output logic      busy,
	output logic      done
);

	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

	typedef struct packed {
		nvmc_tstate_t  st;
		logic [CW-1:0] cnt;
		logic          done;
	} nvmc_tmr_t;

	nvmc_tmr_t q;
	nvmc_tmr_t d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		unique case (q.st)
			NVMC_T_IDLE: begin
				if (start && !abort) begin
					d.st = NVMC_T_RUN;
					d.cnt = LOAD;
				end
			end
			NVMC_T_RUN: begin
				// abort wins so a cut-short cycle never reports completion
				if (abort) begin
					d.st = NVMC_T_IDLE;
				end else if (q.cnt == '0) begin
					d.st = NVMC_T_IDLE;
					d.done = 1'b1;
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			q <= '0;
		else
			q <= d;
	end

	assign busy = (q.st == NVMC_T_RUN);
	assign done = q.done;

	a_done_ends_run: assert property (@(posedge clk) disable iff (!rst_b)
		done |-> !busy && $past(busy))
		else $error("completion pulse without a running cycle");

endmodule // nvmc_prog_timer

// ---- verification/nvmc_ctrl_bench.sv ----
`timescale 1ns/100ps
module nvmc_ctrl_bench;
	import nvmc_pkg::*;
	// short programming time keeps the timed cycle visible within a few bus accesses
	localparam int unsigned PCYC = 20;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        abort_reset = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = HSIZE_WORD;
	logic        hreadyout, hresp, irq;
	logic        mem_prog_sel, mem_cfg_sel, mem_row_erase;
	logic        mem_write_start, mem_read_strobe, mem_write_busy;
	logic [31:0] hrdata;
	logic        rd_ph = 1'b0;
	logic [31:0] exp_q[$];
	logic [7:0]  sel;
	int          fail_count = 0;
	int          check_count = 0;
	int          cyc = 0;

	nvmc_ctrl #(.PROG_CYCLES(PCYC)) nvmc_ctrl_inst (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .abort_reset(abort_reset),
		.mem_prog_sel(mem_prog_sel), .mem_cfg_sel(mem_cfg_sel), .mem_row_erase(mem_row_erase),
		.mem_write_start(mem_write_start), .mem_read_strobe(mem_read_strobe),
		.mem_write_busy(mem_write_busy), .irq(irq));

	always #5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// address phase held until hready is seen high
	task automatic addr_phase(input logic [7:0] a, input logic w);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
		addr_phase(a, 1'b1);
		hwdata <= {24'h0, d};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		#1;
	endtask

	task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
		exp_q.push_back(exp);
		addr_phase(a, 1'b0);
		rd_ph <= 1'b1;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd_ph <= 1'b0;
		#1;
	endtask

	// read data is taken at the edge that ends the data phase
	always @(posedge clk) begin
		if (rd_ph && hreadyout === 1'b1)
			check(hrdata, exp_q.pop_front());
	end

	// ceiling well above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			end_sim();
		end
	end

	initial begin
		void'($urandom(98));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		check({31'h0, hreadyout}, 32'h1);
		check({31'h0, hresp}, 32'h0);
		bus_read(CTRL_OFF, 32'h0);
		bus_read(IRQ_STAT_OFF, 32'h0);
		bus_read(IRQ_MASK_OFF, 32'h0);
		bus_read(8'h0c, 32'h0);
		// start without write permit
		bus_write(CTRL_OFF, 8'h02);
		check({31'h0, mem_write_start}, 32'h0);
		check({31'h0, irq}, 32'h0);
		bus_read(CTRL_OFF, 32'h08);
		bus_read(IRQ_STAT_OFF, 32'h02);
		bus_read(IRQ_STAT_OFF, 32'h00);
		bus_write(IRQ_MASK_OFF, 8'h07);
		bus_write(CTRL_OFF, 8'h00);
		bus_read(CTRL_OFF, 32'h00);
		// full timed row erase on program memory
		bus_write(CTRL_OFF, 8'h94);
		bus_write(CTRL_OFF, 8'h96);
		check({31'h0, mem_write_start}, 32'h1);
		check({31'h0, mem_prog_sel}, 32'h1);
		check({31'h0, mem_row_erase}, 32'h1);
		@(posedge clk);
		#1;
		check({31'h0, mem_write_busy}, 32'h1);
		bus_read(CTRL_OFF, 32'h96);
		bus_write(CTRL_OFF, 8'h04);
		bus_read(CTRL_OFF, 32'h96);
		for (int i = 0; i < 60 && mem_write_busy !== 1'b0; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		#1;
		check({31'h0, irq}, 32'h1);
		check({31'h0, mem_row_erase}, 32'h0);
		bus_read(CTRL_OFF, 32'h84);
		bus_read(IRQ_STAT_OFF, 32'h01);
		check({31'h0, irq}, 32'h0);
		// device reset in the launch cycle with random selects
		for (int k = 0; k < 4; k++) begin
			sel = {2'($urandom_range(3, 0)), 6'h0};
			bus_write(CTRL_OFF, sel | 8'h04);
			bus_write(CTRL_OFF, sel | 8'h06);
			abort_reset <= 1'b1;
			@(posedge clk);
			abort_reset <= 1'b0;
			@(posedge clk);
			#1;
			check({31'h0, mem_write_busy}, 32'h0);
			check({31'h0, irq}, 32'h1);
			check({31'h0, mem_prog_sel}, {31'h0, sel[7]});
			check({31'h0, mem_cfg_sel}, {31'h0, sel[6]});
			bus_read(CTRL_OFF, {24'h0, sel | 8'h08});
			bus_read(IRQ_STAT_OFF, 32'h02);
		end
		// read start under each select combination
		for (int k = 0; k < 4; k++) begin
			sel = 8'(k << 6);
			bus_write(CTRL_OFF, sel);
			bus_write(CTRL_OFF, sel | 8'h01);
			check({31'h0, mem_read_strobe}, {31'h0, sel == 8'h0});
			@(posedge clk);
			#1;
			check({31'h0, mem_read_strobe}, 32'h0);
			bus_read(CTRL_OFF, {24'h0, sel});
			bus_read(IRQ_STAT_OFF, (sel == 8'h0) ? 32'h04 : 32'h00);
		end
		end_sim();
	end
endmodule // nvmc_ctrl_bench
